// file: rtl/fppc_ctrl.sv
/*
 flash program and protection controller with an axi4-lite register slave.
 assumes synchronous inputs on aclk, a single write and read in flight.
*/
// Operation
// - status read returns raw or enable-gated interrupt bits per masked select
// - interrupt status has a program bit and an access bit
// - busy stays set until every word is written or a word faults, then done
// - a programming fault reports failure instead of success
// - each 2 kB block holds rw, ro or xo and is readable
// - rw allows all; ro refuses erase and program
// - xo allows only instruction fetch; data reads refused
// - rw may go to ro or xo, ro may go to xo
// - loosening a level is blocked and fails
// - xo blocks refuse every further change
// - uncommitted protection reverts to committed values on reset
// - protection commit stores settings permanently, done after storage
// - invalid block or undefined level is rejected with failure
// - writable clocks per microsecond times both word programming and commit storage
// - clocks per microsecond reads back
// - two user registers are writable and readable
// - user commit makes values permanent, failure on fault
// - disallowed access raises the access interrupt source
// - completed programming raises the program interrupt source
`timescale 1ns/1ns
`default_nettype none
module fppc_ctrl #(
   parameter int NUM_BLOCKS = 16,
   parameter int CLK_MHZ = 20
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic clk_en,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic flash_fault,
   output logic flash_wr_en,
   output logic [31:0] flash_wr_addr,
   output logic [31:0] flash_wr_data
);
   import fppc_pkg::*;
   localparam int BW = $clog2(NUM_BLOCKS);
   localparam int PROG_CYC0 = PROG_TIME_US * CLK_MHZ;
   localparam int STORE_CYC0 = STORE_TIME_US * CLK_MHZ;
   ////////////////////////////////////////////////////////////////////////////////
   // state
   fppc_state_t st_reg;
   logic [1:0] prot_reg [NUM_BLOCKS];
   // committed copies model permanent storage: factory state until the first commit
   logic [1:0] prot_saved_reg [NUM_BLOCKS] = '{default: PROT_RESET};
   logic [31:0] addr_reg, count_reg, usec_reg, user0_reg, user1_reg;
   logic [31:0] user0_saved_reg = 32'h0;
   logic [31:0] user1_saved_reg = 32'h0;
   logic [31:0] timer_reg;
   logic [1:0] inten_reg, intst_reg;
   logic busy_reg, fail_reg, data_req_reg, masked_reg, saving_prot_reg;
   logic [31:0] prot_query_reg;
   logic aw_held, w_held;
   logic [7:0] aw_addr_reg;
   logic [31:0] w_data_reg;
   ////////////////////////////////////////////////////////////////////////////////
   // decode
   wire wr_go = aw_held && w_held && !s_axi_bvalid;
   wire [7:0] wa = aw_addr_reg;
   wire wr_ctrl = wr_go && wa == OFS_CTRL;
   wire idle = st_reg == FPPC_IDLE;
   wire [31:0] pq_blk = prot_query_reg >> BLOCK_SHIFT;
   wire pq_ok = pq_blk < NUM_BLOCKS;
   wire [BW-1:0] pq_idx = pq_blk[BW-1:0];
   wire [1:0] cur_lvl = pq_ok ? prot_reg[pq_idx] : prot_level_rw;
   wire [1:0] new_lvl = w_data_reg[9:8];
   wire lvl_ok = new_lvl == prot_level_rw || new_lvl == prot_level_ro
                 || new_lvl == prot_level_xo;
   // rw to anything, ro only to ro or xo, xo to nothing new
   wire step_ok = cur_lvl == prot_level_rw
                  || (cur_lvl == prot_level_ro && new_lvl != prot_level_rw)
                  || (cur_lvl == prot_level_xo && new_lvl == prot_level_xo);
   wire pset_cmd = wr_ctrl && w_data_reg[CMD_PSET] && idle;
   wire pset_good = pq_ok && lvl_ok && step_ok;
   wire prog_cmd = wr_ctrl && w_data_reg[CMD_PROG] && idle;
   wire [31:0] pg_blk = addr_reg >> BLOCK_SHIFT;
   wire pg_allow = pg_blk < NUM_BLOCKS
                   && prot_reg[pg_blk[BW-1:0]] == prot_level_rw;
   wire aligned = addr_reg[1:0] == 2'h0 && count_reg[1:0] == 2'h0;
   wire save_cmd = wr_ctrl && (w_data_reg[CMD_PSAVE] || w_data_reg[CMD_USAVE]) && idle;
   wire data_wr = wr_go && wa == OFS_DATA;
   wire acc_wr = wr_go && wa == OFS_ACCESS;
   // access check looks at the address being written, not the previous query
   wire [31:0] ac_blk = w_data_reg >> BLOCK_SHIFT;
   wire ac_ok = ac_blk < NUM_BLOCKS;
   wire [1:0] acc_lvl = ac_ok ? prot_reg[ac_blk[BW-1:0]] : prot_level_rw;
   wire acc_bad = acc_wr && (!ac_ok
                  || (w_data_reg[ACC_READ] && acc_lvl == prot_level_xo)
                  || (w_data_reg[ACC_WRITE] && acc_lvl != prot_level_rw));
   wire prog_end = st_reg == FPPC_PROG && timer_reg == 32'h0;
   wire last_word = count_reg == 32'h4;
   wire ev_prog = (prog_end && (last_word || flash_fault))
                  || (st_reg == FPPC_STORE && timer_reg == 32'h0);
   wire ev_acc = acc_bad || (prog_cmd && (!pg_allow || !aligned));
   wire intst_clr = wr_go && wa == OFS_INTST;
   wire [1:0] int_view = masked_reg ? (intst_reg & inten_reg) : intst_reg;
   wire [31:0] usec_cyc = (usec_reg == 32'h0) ? 32'h1 : usec_reg;
   wire [31:0] rd_mux =
      s_axi_araddr == OFS_STATUS ? {29'h0, data_req_reg, fail_reg, busy_reg} :
      s_axi_araddr == OFS_CTRL ? {27'h0, masked_reg, 4'h0} :
      s_axi_araddr == OFS_ADDR ? addr_reg :
      s_axi_araddr == OFS_COUNT ? count_reg :
      s_axi_araddr == OFS_PROT ? {22'h0, cur_lvl, 8'h0} :
      s_axi_araddr == OFS_USEC ? usec_reg :
      s_axi_araddr == OFS_USER0 ? user0_reg :
      s_axi_araddr == OFS_USER1 ? user1_reg :
      s_axi_araddr == OFS_INTEN ? {30'h0, inten_reg} :
      s_axi_araddr == OFS_INTST ? {30'h0, int_view} : 32'h0;
   wire rd_hit = s_axi_araddr <= OFS_ACCESS && s_axi_araddr[1:0] == 2'h0;
   wire wr_hit = wa <= OFS_ACCESS && wa[1:0] == 2'h0 && wa != OFS_STATUS;
   ////////////////////////////////////////////////////////////////////////////////
   // axi4-lite write and read channels
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr_reg <= 8'h0;
         w_data_reg <= 32'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= AXI_OKAY;
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp <= AXI_OKAY;
         s_axi_rdata <= 32'h0;
      end else if (clk_en) begin
         s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
         s_axi_wready <= !w_held && !s_axi_wready && s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data_reg <= s_axi_wdata;
         end
         if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? AXI_OKAY : AXI_SLVERR;
            aw_held <= 1'b0;
            w_held <= 1'b0;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_mux;
            s_axi_rresp <= rd_hit ? AXI_OKAY : AXI_SLVERR;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   // protection table, committed copy survives reset
   for (genvar b = 0; b < NUM_BLOCKS; b++) begin : g_prot
      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            prot_reg[b] <= prot_saved_reg[b];
         end else if (clk_en) begin
            if (pset_cmd && pset_good && pq_idx == BW'(b)) begin
               prot_reg[b] <= new_lvl;
            end
            if (saving_prot_reg && ev_prog && !flash_fault) begin
               prot_saved_reg[b] <= prot_reg[b];
            end
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   // sequencer
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_reg <= FPPC_IDLE;
         addr_reg <= 32'h0;
         count_reg <= 32'h0;
         usec_reg <= USEC_RESET;
         user0_reg <= user0_saved_reg;
         user1_reg <= user1_saved_reg;
         inten_reg <= 2'h0;
         intst_reg <= 2'h0;
         busy_reg <= 1'b0;
         fail_reg <= 1'b0;
         data_req_reg <= 1'b0;
         masked_reg <= 1'b0;
         saving_prot_reg <= 1'b0;
         prot_query_reg <= 32'h0;
         timer_reg <= 32'h0;
         flash_wr_en <= 1'b0;
         flash_wr_addr <= 32'h0;
         flash_wr_data <= 32'h0;
      end else if (clk_en) begin
         flash_wr_en <= 1'b0;
         intst_reg <= (intst_reg & ~(intst_clr ? w_data_reg[1:0] : 2'h0))
                      | {ev_acc, ev_prog};
         if (wr_go && wa == OFS_ADDR && idle) addr_reg <= w_data_reg;
         if (wr_go && wa == OFS_COUNT && idle) count_reg <= w_data_reg;
         if (wr_go && (wa == OFS_PROT || wa == OFS_ACCESS)) prot_query_reg <= w_data_reg;
         if (wr_go && wa == OFS_USEC && idle) usec_reg <= w_data_reg;
         if (wr_go && wa == OFS_USER0 && idle) user0_reg <= w_data_reg;
         if (wr_go && wa == OFS_USER1 && idle) user1_reg <= w_data_reg;
         if (wr_go && wa == OFS_INTEN) inten_reg <= w_data_reg[1:0];
         if (wr_ctrl) masked_reg <= w_data_reg[CMD_MASKED];
         if (pset_cmd) fail_reg <= !pset_good;
         case (st_reg)
            FPPC_IDLE: begin
               if (prog_cmd) begin
                  if (!pg_allow || !aligned || count_reg == 32'h0) begin
                     fail_reg <= 1'b1;
                  end else begin
                     fail_reg <= 1'b0;
                     busy_reg <= 1'b1;
                     data_req_reg <= 1'b1;
                     st_reg <= FPPC_WAIT;
                  end
               end else if (save_cmd) begin
                  fail_reg <= 1'b0;
                  busy_reg <= 1'b1;
                  saving_prot_reg <= w_data_reg[CMD_PSAVE];
                  timer_reg <= 32'(STORE_CYC0) * usec_cyc / 32'(CLK_MHZ);
                  st_reg <= FPPC_STORE;
               end
            end
            FPPC_WAIT: begin
               if (data_wr) begin
                  data_req_reg <= 1'b0;
                  flash_wr_en <= 1'b1;
                  flash_wr_addr <= addr_reg;
                  flash_wr_data <= w_data_reg;
                  timer_reg <= 32'(PROG_CYC0) * usec_cyc / 32'(CLK_MHZ);
                  st_reg <= FPPC_PROG;
               end
            end
            FPPC_PROG: begin
               if (timer_reg != 32'h0) begin
                  timer_reg <= timer_reg - 32'h1;
               end else if (flash_fault) begin
                  fail_reg <= 1'b1;
                  st_reg <= FPPC_DONE;
               end else if (last_word) begin
                  st_reg <= FPPC_DONE;
               end else begin
                  addr_reg <= addr_reg + 32'h4;
                  count_reg <= count_reg - 32'h4;
                  data_req_reg <= 1'b1;
                  st_reg <= FPPC_WAIT;
               end
            end
            FPPC_STORE: begin
               if (timer_reg != 32'h0) begin
                  timer_reg <= timer_reg - 32'h1;
               end else begin
                  fail_reg <= flash_fault;
                  if (!flash_fault && !saving_prot_reg) begin
                     user0_saved_reg <= user0_reg;
                     user1_saved_reg <= user1_reg;
                  end
                  st_reg <= FPPC_DONE;
               end
            end
            FPPC_DONE: begin
               busy_reg <= 1'b0;
               data_req_reg <= 1'b0;
               saving_prot_reg <= 1'b0;
               st_reg <= FPPC_IDLE;
            end
            default: st_reg <= FPPC_IDLE;
         endcase
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   // checks
   sequence s_word_wait;
      st_reg == FPPC_WAIT && data_wr;
   endsequence
   a_busy_until_done: assert property (@(posedge aclk) disable iff (!aresetn)
      (st_reg == FPPC_PROG) |-> busy_reg) else $error("busy dropped mid program");
   a_word_strobe: assert property (@(posedge aclk) disable iff (!aresetn)
      (s_word_wait and clk_en) |=> flash_wr_en) else $error("word not written");
   a_xo_locked: assert property (@(posedge aclk) disable iff (!aresetn)
      (clk_en && pset_cmd && cur_lvl == prot_level_xo && new_lvl != prot_level_xo)
      |=> fail_reg) else $error("xo block changed");
   a_no_loosen: assert property (@(posedge aclk) disable iff (!aresetn)
      (clk_en && pset_cmd && cur_lvl == prot_level_ro && new_lvl == prot_level_rw)
      |=> fail_reg && prot_reg[$past(pq_idx)] == prot_level_ro)
      else $error("ro loosened");
   a_bad_level: assert property (@(posedge aclk) disable iff (!aresetn)
      (clk_en && pset_cmd && !lvl_ok) |=> fail_reg) else $error("bad level taken");
   a_xo_read: assert property (@(posedge aclk) disable iff (!aresetn)
      (clk_en && acc_wr && ac_ok && w_data_reg[ACC_READ] && acc_lvl == prot_level_xo)
      |=> intst_reg[INT_ACCESS]) else $error("xo read not flagged");
   a_ro_prog: assert property (@(posedge aclk) disable iff (!aresetn)
      (clk_en && prog_cmd && !pg_allow) |=> fail_reg && !busy_reg)
      else $error("ro program started");
   a_fault_fail: assert property (@(posedge aclk) disable iff (!aresetn)
      (clk_en && prog_end && flash_fault) |=> fail_reg) else $error("fault not reported");
   a_masked_view: assert property (@(posedge aclk) disable iff (!aresetn)
      (clk_en && s_axi_arvalid && s_axi_arready && s_axi_araddr == OFS_INTST && masked_reg)
      |=> (s_axi_rdata[1:0] & ~$past(inten_reg)) == 2'h0) else $error("masked leak");
   a_raw_view: assert property (@(posedge aclk) disable iff (!aresetn)
      (clk_en && s_axi_arvalid && s_axi_arready && s_axi_araddr == OFS_INTST && !masked_reg)
      |=> s_axi_rdata[1:0] == $past(intst_reg)) else $error("raw status wrong");
endmodule : fppc_ctrl
`default_nettype wire

// file: shared/fppc_pkg.sv
/*
 package for the flash program and protection controller: register offsets,
 field positions, reset values, protection encodings and sequencer states.
 assumes a 32-bit axi4-lite register bus and a single clock.
*/
`default_nettype none
package fppc_pkg;
   // register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_ADDR = 8'h08;
   localparam logic [7:0] OFS_COUNT = 8'h0c;
   localparam logic [7:0] OFS_DATA = 8'h10;
   localparam logic [7:0] OFS_PROT = 8'h14;
   localparam logic [7:0] OFS_USEC = 8'h18;
   localparam logic [7:0] OFS_USER0 = 8'h1c;
   localparam logic [7:0] OFS_USER1 = 8'h20;
   localparam logic [7:0] OFS_INTEN = 8'h24;
   localparam logic [7:0] OFS_INTST = 8'h28;
   localparam logic [7:0] OFS_ACCESS = 8'h2c;
   // ctrl command bits
   localparam int CMD_PROG = 0;
   localparam int CMD_PSET = 1;
   localparam int CMD_PSAVE = 2;
   localparam int CMD_USAVE = 3;
   localparam int CMD_MASKED = 4;
   // status bits
   localparam int ST_BUSY = 0;
   localparam int ST_FAIL = 1;
   localparam int ST_DATA_REQ = 2;
   // interrupt bits
   localparam int INT_PROGRAM = 0;
   localparam int INT_ACCESS = 1;
   // access check: bit 0 fetch, 1 read, 2 write/erase
   localparam int ACC_FETCH = 0;
   localparam int ACC_READ = 1;
   localparam int ACC_WRITE = 2;
   // protection levels
   localparam logic [1:0] prot_level_rw = 2'h0;
   localparam logic [1:0] prot_level_ro = 2'h1;
   localparam logic [1:0] prot_level_xo = 2'h2;
   localparam logic [1:0] PROT_RESET = 2'h0;
   localparam logic [31:0] USEC_RESET = 32'h0000_0014;
   // word program pulse in microseconds
   localparam int PROG_TIME_US = 1;
   localparam int STORE_TIME_US = 1;
   // bit position of the 2 kB protection block number within an address
   localparam int BLOCK_SHIFT = 11;
   localparam logic [1:0] AXI_OKAY = 2'h0;
   localparam logic [1:0] AXI_SLVERR = 2'h2;
   typedef enum logic [4:0] {
      FPPC_IDLE = 5'h01,
      FPPC_WAIT = 5'h02,
      FPPC_PROG = 5'h04,
      FPPC_STORE = 5'h08,
      FPPC_DONE = 5'h10
   } fppc_state_t;
endpackage : fppc_pkg
`default_nettype wire

// file: tb/fppc_ctrl_tb.sv
/*
 testbench for the flash controller: axi4-lite tasks and directed sequences.
 assumes the flash model on the write port and a 20 mhz clock.
*/
`timescale 1ns/1ns
`default_nettype none
module fppc_ctrl_tb;
   import fppc_pkg::*;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata, rv, wa, wd;
   logic awready, wready, bvalid, arready, rvalid, fault_on = 1'b0, fault, wen, twice;
   logic [1:0] bresp, rresp, resp;
   logic msel = 1'b0;
   logic cken = 1'b1;
   int n_mismatch = 0, total_checks = 0, nw;
   logic [31:0] la, ld;
   always #25 aclk = ~aclk;
   fppc_ctrl i_fppc_ctrl (.aclk(aclk), .aresetn(aresetn), .clk_en(cken),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .flash_fault(fault), .flash_wr_en(wen), .flash_wr_addr(wa), .flash_wr_data(wd));
   fppc_flash_model i_fppc_flash_model (.aclk(aclk), .flash_wr_en(wen), .flash_wr_addr(wa),
      .flash_wr_data(wd), .fault_on(fault_on), .flash_fault(fault), .n_words(nw),
      .last_addr(la), .last_data(ld), .twice(twice));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic report_and_stop();
      if (n_mismatch == 0 && total_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : report_and_stop
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      total_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      resp = bresp;
      bready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready === 1'b1) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      rv = rdata;
      resp = rresp;
      rready <= 1'b0;
   endtask : rd
   function automatic logic [31:0] cv(input logic [31:0] c);
      cv = c | ({31'h0, msel} << CMD_MASKED);
   endfunction : cv
   // leaves the final status word in rv
   task automatic idle();
      do rd(OFS_STATUS); while (rv[ST_BUSY] !== 1'b0);
   endtask : idle
   task automatic cmd(input int b);
      wr(OFS_CTRL, cv(32'h1 << b));
      idle();
   endtask : cmd
   task automatic pset(input logic [31:0] a, input logic [1:0] l);
      wr(OFS_PROT, a);
      wr(OFS_CTRL, cv({22'h0, l, 8'h02}));
      idle();
   endtask : pset
   task automatic prot_is(input logic [31:0] a, input logic [1:0] l);
      wr(OFS_PROT, a);
      rd(OFS_PROT);
      chk({30'h0, rv[9:8]}, {30'h0, l});
   endtask : prot_is
   task automatic prog(input logic [31:0] a, input int n, input logic [31:0] d);
      wr(OFS_ADDR, a);
      wr(OFS_COUNT, 32'(n * 4));
      wr(OFS_CTRL, cv(32'h1 << CMD_PROG));
      for (int i = 0; i < n; i++) begin
         do rd(OFS_STATUS); while (rv[ST_DATA_REQ] !== 1'b1 && rv[ST_BUSY] !== 1'b0);
         if (rv[ST_DATA_REQ] === 1'b1) begin
            chk(32'(rv[ST_BUSY]), 32'h1);
            wr(OFS_DATA, d + 32'(i));
         end
      end
      idle();
   endtask : prog
   task automatic rst();
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
   endtask : rst
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      #(50 * 40000);
      n_mismatch++;
      report_and_stop();
   end
   initial begin
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      rd(OFS_USEC);
      chk(rv, USEC_RESET);
      wr(OFS_USEC, 32'h2);
      rd(OFS_USEC);
      chk(rv, 32'h2);
      wr(OFS_USER0, 32'h5a5a_0f0f);
      wr(OFS_USER1, 32'h0000_c3c3);
      rd(OFS_USER0);
      chk(rv, 32'h5a5a_0f0f);
      rd(OFS_USER1);
      chk(rv, 32'h0000_c3c3);
      cmd(CMD_PSAVE);
      chk(32'(rv[ST_FAIL]), 32'h0);
      cmd(CMD_USAVE);
      chk(32'(rv[ST_FAIL]), 32'h0);
      wr(OFS_INTST, 32'h3);
      prog(32'h0, 2, 32'h1234_0000);
      chk(32'(rv[ST_FAIL]), 32'h0);
      chk(32'(nw), 32'h2);
      chk(la, 32'h4);
      chk(ld, 32'h1234_0001);
      rd(OFS_INTST);
      chk(rv, 32'h1);
      wr(OFS_INTEN, 32'h0);
      msel = 1'b1;
      wr(OFS_CTRL, cv(32'h0));
      rd(OFS_INTST);
      chk(rv, 32'h0);
      wr(OFS_INTEN, 32'h1);
      rd(OFS_INTST);
      chk(rv, 32'h1);
      msel = 1'b0;
      wr(OFS_CTRL, cv(32'h0));
      wr(OFS_INTEN, 32'h0);
      rd(OFS_INTST);
      chk(rv, 32'h1);
      fault_on <= 1'b1;
      prog(32'h10, 1, 32'h0000_abcd);
      chk(32'(rv[ST_FAIL]), 32'h1);
      fault_on <= 1'b0;
      pset(32'h800, prot_level_ro);
      chk(32'(rv[ST_FAIL]), 32'h0);
      prot_is(32'h800, prot_level_ro);
      pset(32'h800, prot_level_rw);
      chk(32'(rv[ST_FAIL]), 32'h1);
      prot_is(32'h800, prot_level_ro);
      pset(32'h800, prot_level_xo);
      chk(32'(rv[ST_FAIL]), 32'h0);
      pset(32'h800, prot_level_ro);
      chk(32'(rv[ST_FAIL]), 32'h1);
      prot_is(32'h800, prot_level_xo);
      pset(32'h1800, 2'h3);
      chk(32'(rv[ST_FAIL]), 32'h1);
      pset(32'h8000, prot_level_ro);
      chk(32'(rv[ST_FAIL]), 32'h1);
      wr(OFS_INTST, 32'h3);
      wr(OFS_ACCESS, 32'h802);
      rd(OFS_INTST);
      chk(rv, 32'h2);
      wr(OFS_INTST, 32'h3);
      wr(OFS_ACCESS, 32'h801);
      rd(OFS_INTST);
      chk(rv, 32'h0);
      wr(OFS_ACCESS, 32'h0002);
      rd(OFS_INTST);
      chk(rv, 32'h0);
      pset(32'h1800, prot_level_ro);
      wr(OFS_ACCESS, 32'h1802);
      rd(OFS_INTST);
      chk(rv, 32'h0);
      prog(32'h1800, 1, 32'h0);
      chk(32'(rv[ST_FAIL]), 32'h1);
      chk(32'(nw), 32'h3);
      rd(OFS_INTST);
      chk(32'(rv[INT_ACCESS]), 32'h1);
      rst();
      prot_is(32'h800, prot_level_rw);
      rd(OFS_USER1);
      chk(rv, 32'h0000_c3c3);
      pset(32'h1000, prot_level_ro);
      cmd(CMD_PSAVE);
      chk(32'(rv[ST_FAIL]), 32'h0);
      rst();
      prot_is(32'h1000, prot_level_ro);
      wr(OFS_CTRL, cv(32'h1 << CMD_USAVE));
      @(posedge aclk) cken <= 1'b0;
      repeat (40) @(posedge aclk);
      cken <= 1'b1;
      rd(OFS_STATUS);
      chk(32'(rv[ST_BUSY]), 32'h1);
      idle();
      fault_on <= 1'b1;
      cmd(CMD_USAVE);
      chk(32'(rv[ST_FAIL]), 32'h1);
      fault_on <= 1'b0;
      rd(8'h30);
      chk({30'h0, resp}, {30'h0, AXI_SLVERR});
      wr(OFS_STATUS, 32'h0);
      chk({30'h0, resp}, {30'h0, AXI_SLVERR});
      chk(32'(twice), 32'h0);
      report_and_stop();
   end
endmodule : fppc_ctrl_tb
`default_nettype wire

// file: tb/fppc_flash_model.sv
/*
 flash array model: records every programmed word and drives the fault level.
 assumes the controller pulses flash_wr_en for one aclk cycle per word.
*/
`timescale 1ns/1ns
`default_nettype none
module fppc_flash_model (
   input wire logic aclk,
   input wire logic flash_wr_en,
   input wire logic [31:0] flash_wr_addr,
   input wire logic [31:0] flash_wr_data,
   input wire logic fault_on,
   output logic flash_fault,
   output int n_words,
   output logic [31:0] last_addr,
   output logic [31:0] last_data,
   output logic twice
);
   // one mark per word of the protected range
   bit seen [8192];
   ////////////////////////////////////////////////////////////////////////////////
   // fault level seen at the end of each word or store
   assign flash_fault = fault_on;
   initial begin
      n_words = 0;
      twice = 1'b0;
      last_addr = 32'h0;
      last_data = 32'h0;
   end
   // flags a second program of one word without erase
   always @(posedge aclk) begin
      if (flash_wr_en === 1'b1) begin
         if (seen[flash_wr_addr[14:2]]) twice <= 1'b1;
         seen[flash_wr_addr[14:2]] = 1'b1;
         n_words <= n_words + 1;
         last_addr <= flash_wr_addr;
         last_data <= flash_wr_data;
      end
   end
endmodule : fppc_flash_model
`default_nettype wire
